// ### fpt_byte_sel.sv
// Combinational builder of dword 11 and byte selector for the window.
// Assumes addr and dens_256 are stable in the sys_clk domain.
`timescale 1ns/10ps
`default_nettype none
module fpt_byte_sel (
  input wire logic [7:0] addr,
  input wire logic dens_256,
  output logic [7:0] byte_out,
  output logic hit
);

  // ------------------------------------------------------------------
  // Dword assembly
  // ------------------------------------------------------------------
  // Erase fields depend on the density variant
  wire logic [1:0] ce_unit;
  wire logic [4:0] ce_cnt;
  wire logic [31:0] dword11;

  assign ce_unit = dens_256 ? fpt_pkg::CE_UNIT_64S : fpt_pkg::CE_UNIT_4S;
  assign ce_cnt = dens_256 ? fpt_pkg::CE_CNT_256 : fpt_pkg::CE_CNT_128;

  // reserved bit on top
  // Packed field by field so the encodings stay visible
  assign dword11 = {fpt_pkg::RSVD_VAL, ce_unit, ce_cnt,
                    fpt_pkg::AB_UNIT_VAL, fpt_pkg::AB_CNT_VAL,
                    fpt_pkg::FB_UNIT_VAL, fpt_pkg::FB_CNT_VAL,
                    fpt_pkg::PP_UNIT_VAL, fpt_pkg::PP_CNT_VAL,
                    fpt_pkg::PG_EXP_VAL, fpt_pkg::PP_MUL_VAL};

  // ------------------------------------------------------------------
  // Byte select
  // ------------------------------------------------------------------
  // Ascending address returns ascending significance
  wire logic sel_b0;
  wire logic sel_b1;
  wire logic sel_b2;
  wire logic sel_b3;
  wire logic sel_c0;

  assign sel_b0 = (addr == fpt_pkg::ADDR_DW11_B0);
  assign sel_b1 = (addr == fpt_pkg::ADDR_DW11_B1);
  assign sel_b2 = (addr == fpt_pkg::ADDR_DW11_B2);
  assign sel_b3 = (addr == fpt_pkg::ADDR_DW11_B3);
  assign sel_c0 = (addr == fpt_pkg::ADDR_DW12_B0);

  assign hit = sel_b0 | sel_b1 | sel_b2 | sel_b3 | sel_c0;
  assign byte_out = sel_b0 ? dword11[7:0] :
                    sel_b1 ? dword11[15:8] :
                    sel_b2 ? dword11[23:16] :
                    sel_b3 ? dword11[31:24] :
                    sel_c0 ? fpt_pkg::DW12_B0_VAL : fpt_pkg::MISS_VAL;

endmodule
`default_nettype wire

// ### fpt_host_model.sv
// Behavioural host that issues byte reads to the parameter-table port.
// Assumes it shares sys_clk with the table; driven from the bench by tasks.
`timescale 1ns/10ps
`default_nettype none
module fpt_host_model (
  input wire logic sys_clk,
  output logic rd_req,
  output logic [7:0] rd_addr
);
  // ----------------------------------------------------------------
  // Request drive
  // ----------------------------------------------------------------
  initial begin
    rd_req = 1'b0;
    rd_addr = 8'h00;
  end

  // One-cycle request per byte; calls may follow back to back
  task automatic read(input logic [7:0] a);
    @(negedge sys_clk);
    rd_req <= 1'b1;
    rd_addr <= a;
  endtask

  // Released address flips to its inverse every idle cycle, so the stale value comes back on every second one
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      rd_req <= 1'b0;
      rd_addr <= ~rd_addr;
    end
  endtask
endmodule
`default_nettype wire

// ### fpt_param_table.sv
// Read port for the timing bytes of the flash parameter table.
// Assumes the read command decoder runs on sys_clk and issues one-cycle
// read requests; the density strap is an asynchronous board pin.
//
// What this block does
// - First byte unit bit reads 0
// - First byte count reads 0111b
// - Page program unit bit reads 1
// - Page program count reads 00100b
// - Page size exponent reads 1000b
// - Max page multiplier count reads 0001b
// - Byte 2Ah reads 29h
// - Chip erase unit code in bits 30:29
// - Small variant byte 2Bh reads D1h
// - Large variant byte 2Bh reads E2h
// - Reserved bit 31 always reads one
// - Byte 2Ch CCh, suspend supported flag 0
`timescale 1ns/10ps
`default_nettype none
module fpt_param_table (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  input wire logic dens_256_pin,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic rd_hit,
  output logic susp_unsup
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic dens_s1_ff;        // First strap flop, read only by second
  logic dens_s2_ff;        // Synchronised density strap
  logic rd_valid_ff;       // Answer strobe
  logic [7:0] rd_data_ff;  // Answer byte
  logic rd_hit_ff;         // Answer address was in this window
  logic susp_unsup_ff;     // Suspend indicator, constant
  logic [7:0] nxt_rd_data; // Byte for the pending request
  logic nxt_rd_hit;        // Hit for the pending request
  wire logic [7:0] sel_byte; // Selector output
  wire logic sel_hit;        // Selector hit

  // ------------------------------------------------------------------
  // Density strap synchroniser
  // ------------------------------------------------------------------
  // The strap is a pin; two flops before anything looks at it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dens_s1_ff <= 1'b0;
      dens_s2_ff <= 1'b0;
    end else begin
      dens_s1_ff <= dens_256_pin;
      dens_s2_ff <= dens_s1_ff;
    end
  end

  // ------------------------------------------------------------------
  // Byte selection
  // ------------------------------------------------------------------
  // byte selector for the window
  // constant table lookup
  // The table is pure wiring; nothing in here can be written
  fpt_byte_sel u_sel (
    .addr(rd_addr),
    .dens_256(dens_s2_ff),
    .byte_out(sel_byte),
    .hit(sel_hit)
  );

  // Hold the last answer between requests so the bus stays quiet
  assign nxt_rd_data = rd_req ? sel_byte : rd_data_ff;
  assign nxt_rd_hit = rd_req ? sel_hit : rd_hit_ff;

  // ------------------------------------------------------------------
  // Answer registers
  // ------------------------------------------------------------------
  // one byte per request
  // Each request answers on the next edge; back to back is allowed
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= fpt_pkg::MISS_VAL;
      rd_hit_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_req;
      rd_data_ff <= nxt_rd_data;
      rd_hit_ff <= nxt_rd_hit;
    end
  end

  // suspend supported flag
  // Kept in a flop so every output leaves a register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      susp_unsup_ff <= fpt_pkg::SUSP_UNSUP_VAL;
    end else begin
      susp_unsup_ff <= fpt_pkg::SUSP_UNSUP_VAL;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;
  assign rd_hit = rd_hit_ff;
  assign susp_unsup = susp_unsup_ff;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Named request sequences, one per byte of dword 11 (28h to 2Bh); none for 2Ch
  sequence s_rd_b0;
    rd_req && rd_addr == fpt_pkg::ADDR_DW11_B0;
  endsequence

  sequence s_rd_b1;
    rd_req && rd_addr == fpt_pkg::ADDR_DW11_B1;
  endsequence

  sequence s_rd_b2;
    rd_req && rd_addr == fpt_pkg::ADDR_DW11_B2;
  endsequence

  sequence s_rd_b3;
    rd_req && rd_addr == fpt_pkg::ADDR_DW11_B3;
  endsequence

  // A full little-endian walk of the dword, one byte per cycle
  sequence s_walk_dw11;
    s_rd_b0 ##1 s_rd_b1 ##1 s_rd_b2 ##1 s_rd_b3;
  endsequence

  // First byte unit sits at bit 2 of byte 2Ah
  property p_fb_unit;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b2 |=> rd_valid && rd_data[2] == fpt_pkg::FB_UNIT_VAL;
  endproperty
  a_fb_unit: assert property (p_fb_unit)
    else $error("first byte unit bit wrong");

  // First byte count straddles bytes 29h and 2Ah
  property p_fb_cnt;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b1 ##1 s_rd_b2 |=>
      {rd_data[1:0], $past(rd_data[7:6])} == fpt_pkg::FB_CNT_VAL;
  endproperty
  a_fb_cnt: assert property (p_fb_cnt)
    else $error("first byte count wrong");

  // Page program unit is bit 5 of byte 29h
  property p_pp_unit;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b1 |=> rd_data[5] == fpt_pkg::PP_UNIT_VAL;
  endproperty
  a_pp_unit: assert property (p_pp_unit)
    else $error("page program unit bit wrong");

  // Page program count is bits 4:0 of byte 29h
  property p_pp_cnt;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b1 |=> rd_hit && rd_data[4:0] == fpt_pkg::PP_CNT_VAL;
  endproperty
  a_pp_cnt: assert property (p_pp_cnt)
    else $error("page program count wrong");

  // Page size exponent is the high nibble of byte 28h
  property p_pg_exp;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b0 |=> rd_data[7:4] == fpt_pkg::PG_EXP_VAL;
  endproperty
  a_pg_exp: assert property (p_pg_exp)
    else $error("page size exponent wrong");

  // Multiplier count is the low nibble of byte 28h
  property p_pp_mul;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b0 |=> rd_data[3:0] == fpt_pkg::PP_MUL_VAL;
  endproperty
  a_pp_mul: assert property (p_pp_mul)
    else $error("max page multiplier wrong");

  // Byte 2Ah as a whole
  property p_b2;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b2 |=> rd_data == fpt_pkg::DW11_B2_VAL;
  endproperty
  a_b2: assert property (p_b2)
    else $error("byte 2Ah wrong");

  // Erase unit follows the strap seen at the request
  property p_ce_unit;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b3 |=> rd_data[6:5] == ($past(dens_s2_ff) ?
      fpt_pkg::CE_UNIT_64S : fpt_pkg::CE_UNIT_4S);
  endproperty
  a_ce_unit: assert property (p_ce_unit)
    else $error("chip erase unit wrong");

  // Small variant top byte
  property p_b3_128;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b3 and !dens_s2_ff |=> rd_data == fpt_pkg::DW11_B3_128;
  endproperty
  a_b3_128: assert property (p_b3_128)
    else $error("byte 2Bh wrong for small variant");

  // Large variant top byte
  property p_b3_256;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b3 and dens_s2_ff |=> rd_data == fpt_pkg::DW11_B3_256;
  endproperty
  a_b3_256: assert property (p_b3_256)
    else $error("byte 2Bh wrong for large variant");

  // Reserved bit is one whatever the strap
  property p_rsvd;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b3 |=> rd_data[7] == fpt_pkg::RSVD_VAL;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit not one");

  // Byte 2Ch and the suspend flag
  property p_b2c;
    @(posedge sys_clk) disable iff (!nrst)
    rd_req && rd_addr == fpt_pkg::ADDR_DW12_B0 |=>
      rd_data == fpt_pkg::DW12_B0_VAL && !susp_unsup;
  endproperty
  a_b2c: assert property (p_b2c)
    else $error("byte 2Ch or suspend flag wrong");

  // Walking the dword gives bytes in ascending significance
  property p_walk;
    @(posedge sys_clk) disable iff (!nrst)
    s_walk_dw11 |-> ##1 rd_data == ($past(dens_s2_ff) ?
      fpt_pkg::DW11_B3_256 : fpt_pkg::DW11_B3_128) &&
      $past(rd_data, 1) == fpt_pkg::DW11_B2_VAL &&
      $past(rd_data, 2) == fpt_pkg::DW11_B1_VAL &&
      $past(rd_data, 3) == fpt_pkg::DW11_B0_VAL;
  endproperty
  a_walk: assert property (p_walk)
    else $error("dword byte order wrong");

  // Strobe matches requests exactly, one cycle later
  property p_strobe;
    @(posedge sys_clk) disable iff (!nrst)
    rd_valid == $past(rd_req);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("answer strobe out of step");

  // Outside the window: miss, zero byte
  property p_miss;
    @(posedge sys_clk) disable iff (!nrst)
    rd_req && (rd_addr < fpt_pkg::ADDR_DW11_B0 ||
      rd_addr > fpt_pkg::ADDR_DW12_B0) |=>
      !rd_hit && rd_data == fpt_pkg::MISS_VAL;
  endproperty
  a_miss: assert property (p_miss)
    else $error("miss not reported");

  // Without a request the answer byte stays put
  property p_hold;
    @(posedge sys_clk) disable iff (!nrst)
    !rd_req |=> $stable(rd_data) && $stable(rd_hit);
  endproperty
  a_hold: assert property (p_hold)
    else $error("answer changed without request");

  // Whole low bytes of the dword, so a field packing slip shows
  property p_b0;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b0 |=> rd_hit && rd_data == fpt_pkg::DW11_B0_VAL;
  endproperty
  a_b0: assert property (p_b0)
    else $error("byte 28h wrong");

  property p_b1;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b1 |=> rd_hit && rd_data == fpt_pkg::DW11_B1_VAL;
  endproperty
  a_b1: assert property (p_b1)
    else $error("byte 29h wrong");

  // Erase count follows the strap seen at the request
  property p_ce_cnt;
    @(posedge sys_clk) disable iff (!nrst)
    s_rd_b3 |=> rd_data[4:0] == ($past(dens_s2_ff) ?
      fpt_pkg::CE_CNT_256 : fpt_pkg::CE_CNT_128);
  endproperty
  a_ce_cnt: assert property (p_ce_cnt)
    else $error("chip erase count wrong");

  // A request inside the window always answers with a hit
  property p_hit;
    @(posedge sys_clk) disable iff (!nrst)
    rd_req && rd_addr >= fpt_pkg::ADDR_DW11_B0 &&
      rd_addr <= fpt_pkg::ADDR_DW12_B0 |=> rd_valid && rd_hit;
  endproperty
  a_hit: assert property (p_hit)
    else $error("window read not reported as hit");

endmodule
`default_nettype wire

// ### fpt_pkg.sv
// Constants of the parameter-table timing bytes: addresses, field
// positions, field values and the two density encodings.
// Assumes one consumer clock domain; holds no logic.
package fpt_pkg;

  // ------------------------------------------------------------------
  // Relative byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_DW11_B0 = 8'h28; // Dword 11, bits 7:0
  localparam logic [7:0] ADDR_DW11_B1 = 8'h29; // Dword 11, bits 15:8
  localparam logic [7:0] ADDR_DW11_B2 = 8'h2A; // Dword 11, bits 23:16
  localparam logic [7:0] ADDR_DW11_B3 = 8'h2B; // Dword 11, bits 31:24
  localparam logic [7:0] ADDR_DW12_B0 = 8'h2C; // Dword 12, bits 7:0

  // ------------------------------------------------------------------
  // Dword 11 field positions (low bit of each field)
  // ------------------------------------------------------------------
  localparam int POS_RSVD = 31;       // Reserved, reads one
  localparam int POS_CE_UNIT = 29;    // Chip erase unit, 2 bits
  localparam int POS_CE_CNT = 24;     // Chip erase count, 5 bits
  localparam int POS_AB_UNIT = 23;    // Additional byte unit
  localparam int POS_AB_CNT = 19;     // Additional byte count, 4 bits
  localparam int POS_FB_UNIT = 18;    // First byte unit
  localparam int POS_FB_CNT = 14;     // First byte count, 4 bits
  localparam int POS_PP_UNIT = 13;    // Page program unit
  localparam int POS_PP_CNT = 8;      // Page program count, 5 bits
  localparam int POS_PG_EXP = 4;      // Page size exponent, 4 bits
  localparam int POS_PP_MUL = 0;      // Max/typ multiplier count, 4 bits

  // ------------------------------------------------------------------
  // Dword 11 field values
  // ------------------------------------------------------------------
  localparam logic RSVD_VAL = 1'h1;
  localparam logic AB_UNIT_VAL = 1'h0;          // 1 us
  localparam logic [3:0] AB_CNT_VAL = 4'h5;     // 6 units
  localparam logic FB_UNIT_VAL = 1'h0;          // 1 us
  localparam logic [3:0] FB_CNT_VAL = 4'h7;     // 8 units
  localparam logic PP_UNIT_VAL = 1'h1;          // 64 us
  localparam logic [4:0] PP_CNT_VAL = 5'h04;    // 5 units
  localparam logic [3:0] PG_EXP_VAL = 4'h8;     // 256 byte page
  localparam logic [3:0] PP_MUL_VAL = 4'h1;     // 4x typical

  // Chip erase unit codes
  localparam logic [1:0] CE_UNIT_16MS = 2'h0;
  localparam logic [1:0] CE_UNIT_256MS = 2'h1;
  localparam logic [1:0] CE_UNIT_4S = 2'h2;
  localparam logic [1:0] CE_UNIT_64S = 2'h3;

  // Chip erase per density
  localparam logic [4:0] CE_CNT_128 = 5'h11;    // 18 x 4 s
  localparam logic [4:0] CE_CNT_256 = 5'h02;    // 3 x 64 s

  // ------------------------------------------------------------------
  // Whole bytes as read, and the suspend indicator
  // ------------------------------------------------------------------
  localparam logic [7:0] DW11_B0_VAL = 8'h81;
  localparam logic [7:0] DW11_B1_VAL = 8'hE4;
  localparam logic [7:0] DW11_B2_VAL = 8'h29;
  localparam logic [7:0] DW11_B3_128 = 8'hD1;
  localparam logic [7:0] DW11_B3_256 = 8'hE2;
  localparam logic [7:0] DW12_B0_VAL = 8'hCC;
  localparam logic SUSP_UNSUP_VAL = 1'h0;       // 0: suspend supported
  localparam logic [7:0] MISS_VAL = 8'h00;      // Outside this block

endpackage

// ### testbench.sv
// Self-checking bench for the parameter-table timing bytes.
// Assumes a 40 MHz sys_clk and the host model beside the table.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic sys_clk, nrst, dens_256_pin;
  logic rd_req, rd_valid, rd_hit, susp_unsup;
  logic [7:0] rd_addr, rd_data;
  logic [7:0] seen_b [0:255]; // Last answer seen per address
  logic [11:0] last_ans; // Last answer, hit above data
  int mismatches = 0;
  int comparisons = 0;
  int seed = 50437;
  int exp_q[$]; // Address from bit 9 up, hit in bit 8, byte below
  int exp_v;
  logic [31:0] r;

  fpt_param_table dut_u (.sys_clk(sys_clk), .nrst(nrst), .rd_req(rd_req),
    .rd_addr(rd_addr), .dens_256_pin(dens_256_pin), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_hit(rd_hit), .susp_unsup(susp_unsup));
  fpt_host_model host_u (.sys_clk(sys_clk), .rd_req(rd_req),
    .rd_addr(rd_addr));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Reference model and checking
  // ----------------------------------------------------------------
  // Builds dword 11 from its fields, so a packing slip shows up
  function automatic int model_byte(int a, int d);
    int dw;
    dw = (1 << 31) | ((d ? 3 : 2) << 29) | ((d ? 2 : 17) << 24);
    dw = dw | (5 << 19) | (7 << 14) | (1 << 13) | (4 << 8) | (8 << 4) | 1;
    if (a >= 'h28 && a <= 'h2B) return 256 | ((dw >> (8 * (a - 'h28))) & 255);
    if (a == 'h2C) return 256 | 'hCC;
    return 0;
  endfunction

  task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Expectation queued at the edge that takes a request
  always @(posedge sys_clk) begin
    if (!nrst) begin
      exp_q.delete();
    end else if (rd_req) begin
      exp_q.push_back((int'(rd_addr) << 9) |
        model_byte(rd_addr, dens_256_pin));
    end
  end

  // Every answer is matched to the oldest request
  always @(negedge sys_clk) begin
    if (rd_valid) begin
      if (exp_q.size() == 0) begin
        check("unrequested answer", 12'h001, 12'h000);
      end else begin
        exp_v = exp_q.pop_front();
        check("answer", {3'h0, rd_hit, rd_data}, 12'(exp_v & 511));
        check("susp_unsup", 12'(susp_unsup), 12'h000);
        seen_b[exp_v >> 9] = rd_data;
        last_ans = {3'h0, rd_hit, rd_data};
      end
    end
  end

  // ----------------------------------------------------------------
  // Scenario helpers
  // ----------------------------------------------------------------
  // Idle a while, then nothing pending and the last answer held
  task automatic settle();
    host_u.idle(3);
    check("pending answers", 12'(exp_q.size()), 12'h000);
    check("rd_valid idle", 12'(rd_valid), 12'h000);
    check("held answer", {3'h0, rd_hit, rd_data}, last_ans);
  endtask

  // Whole window back to back, lowest address first
  task automatic burst();
    for (int a = 'h28; a <= 'h2C; a++) begin
      host_u.read(8'(a));
    end
    settle();
  endtask

  // Field view of the dword assembled from ascending bytes
  task automatic fields(logic d);
    logic [31:0] dw;
    dw = {seen_b[8'h2B], seen_b[8'h2A], seen_b[8'h29], seen_b[8'h28]};
    check("first byte unit", 12'(dw[18]), 12'h000);
    check("first byte count", 12'(dw[17:14]), 12'h007);
    check("page unit", 12'(dw[13]), 12'h001);
    check("page count", 12'(dw[12:8]), 12'h004);
    check("page exponent", 12'(dw[7:4]), 12'h008);
    check("max multiplier", 12'(dw[3:0]), 12'h001);
    check("byte 2A", 12'(dw[23:16]), 12'h029);
    check("erase unit", 12'(dw[30:29]), d ? 12'h003 : 12'h002);
    check("erase byte", 12'(dw[31:24]), d ? 12'h0E2 : 12'h0D1);
    check("reserved bit", 12'(dw[31]), 12'h001);
    check("byte 2C", 12'(seen_b[8'h2C]), 12'h0CC);
  endtask

  task automatic summarize();
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under 2000 cycles
  initial begin
    #500000;
    mismatches++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    dens_256_pin = 1'b0;
    last_ans = 12'h000;
    repeat (16) @(negedge sys_clk);
    check("reset answer", {3'h0, rd_hit, rd_data}, 12'h000);
    check("reset flags", {10'h000, rd_valid, susp_unsup}, 12'h000);
    nrst = 1'b1;
    repeat (3) @(negedge sys_clk);
    burst();
    fields(1'b0);
    dens_256_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    burst();
    fields(1'b1);
    // Random addresses, mostly around the window, random gaps
    for (int p = 0; p < 4; p++) begin
      dens_256_pin = 1'($random(seed));
      repeat (4) @(negedge sys_clk);
      repeat (60) begin
        r = $random(seed);
        host_u.read(r[4] ? r[15:8] : 8'h26 + 8'(r[2:0]));
        if (r[5]) host_u.idle(int'(r[7:6]));
      end
      settle();
    end
    // Reset in mid-run clears a held answer; first read right after
    burst();
    @(negedge sys_clk);
    nrst = 1'b0;
    @(negedge sys_clk);
    check("reset clears answer", {3'h0, rd_hit, rd_data}, 12'h000);
    nrst = 1'b1;
    last_ans = 12'h000;
    host_u.read(8'h28);
    host_u.idle(3);
    host_u.read(8'h2B);
    settle();
    summarize();
  end
endmodule
`default_nettype wire
